//--- verification/drbs_master.sv
// Bus master model: single-beat loads and stores towards the RAM slave.
// Assumes a free running clock; the bench calls access() by hierarchy.
`timescale 1ns/1ps
`default_nettype none

module drbs_master
(
    input wire logic clock,
    input wire logic bus_ready,
    input wire logic bus_ack,
    input wire logic [31:0] bus_rdata,
    output logic bus_valid,
    output logic bus_write,
    output logic [1:0] bus_size,
    output logic bus_burst,
    output logic [10:0] bus_addr,
    output logic [31:0] bus_wdata,
    output logic bus_prev_pending
);
    // Idle bus at time zero
    initial
    begin
        bus_valid = 1'b0;
        bus_write = 1'b0;
        bus_size = 2'h0;
        bus_burst = 1'b0;
        bus_addr = 11'h0;
        bus_wdata = 32'h0;
        bus_prev_pending = 1'b0;
    end

    // data traffic only
    // One transfer; lat is the ack cycle counted from the take, 0 if none
    task automatic access(input logic w, input logic [1:0] sz, input logic bu,
        input logic [10:0] a, input logic [31:0] d, input int pend,
        output int lat, output logic [31:0] rd);
        lat = 0;
        rd = 32'h0;
        @(posedge clock);
        bus_valid <= 1'b1;
        bus_write <= w;
        bus_size <= sz;
        bus_burst <= bu;
        bus_addr <= a;
        bus_wdata <= d;
        bus_prev_pending <= (pend > 0);
        // Hold the request until ready is sampled high at an edge
        @(posedge clock);
        while (bus_ready !== 1'b1)
            @(posedge clock);
        // Released address and data lines show inverted values, never the stale ones
        bus_valid <= 1'b0;
        bus_addr <= ~a;
        bus_wdata <= ~d;
        bus_burst <= 1'b0;
        for (int k = 0; k < 16 && lat == 0; k++)
        begin
            if (k >= pend)
                bus_prev_pending <= 1'b0;
            // Ack and read data taken at the same rising edge
            @(posedge clock);
            if (bus_ack === 1'b1)
            begin
                lat = k + 1;
                rd = bus_rdata;
            end
        end
        bus_prev_pending <= 1'b0;
    endtask : access
endmodule : drbs_master
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the RAM slave, a bus master model on its bus.
// Assumes drbs_master sits on the bus side; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b1;
    logic idu_req = 1'b0;
    logic [8:0] idu_addr = 9'h0;
    logic bv, bw, bb, bp, rdy, ack, refd, iack;
    logic [1:0] bs;
    logic [10:0] ba;
    logic [31:0] bd, brd, ird, rd, exp;
    int lat, n_fail = 0, check_count = 0, cyc = 0, n_refd = 0;

    always #12.5 clock = ~clock;

    drbs_top drbs_top_i (.clock(clock), .rst(rst), .direct_ram_access_enable(en),
        .bus_valid(bv), .bus_write(bw), .bus_size(bs), .bus_burst(bb),
        .bus_addr(ba), .bus_wdata(bd), .bus_prev_pending(bp), .bus_ready(rdy),
        .bus_ack(ack), .bus_rdata(brd), .bus_refused(refd), .idu_req(idu_req),
        .idu_addr(idu_addr), .idu_ack(iack), .idu_rdata(ird));
    drbs_master drbs_master_i (.clock(clock), .bus_ready(rdy), .bus_ack(ack),
        .bus_rdata(brd), .bus_valid(bv), .bus_write(bw), .bus_size(bs),
        .bus_burst(bb), .bus_addr(ba), .bus_wdata(bd), .bus_prev_pending(bp));

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want)
        begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, want);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // Hang guard, far above the roughly 155 cycles the run needs
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            test_done();
        end
    end

    // Count refusal pulses seen at the rising edge
    always @(posedge clock)
    begin
        if (refd === 1'b1)
            n_refd++;
    end

    task automatic set_en(input logic v);
        @(posedge clock);
        en <= v;
    endtask : set_en

    // Word load at address a must ack next cycle with the full word
    task automatic ld(input logic [10:0] a, input logic [31:0] want);
        drbs_master_i.access(1'b0, 2'h2, 1'b0, a, 32'h0, 0, lat, rd);
        chk(lat, 1);
        chk(rd, want);
    endtask : ld

    task automatic t_word;
        drbs_master_i.access(1'b1, 2'h2, 1'b0, 11'h014, 32'hcafe_1234, 0, lat, rd);
        chk(lat, 1);
        ld(11'h014, 32'hcafe_1234);
    endtask : t_word

    // Narrow stores touch only their lanes; narrow loads still see all
    task automatic t_lanes;
        exp = 32'h1122_3344;
        drbs_master_i.access(1'b1, 2'h2, 1'b0, 11'h020, exp, 0, lat, rd);
        for (int n = 0; n < 4; n++)
        begin
            drbs_master_i.access(1'b1, 2'h0, 1'b0, 11'h020 + 11'(n),
                32'(8'ha0 + n), 0, lat, rd);
            chk(lat, 1);
            exp[8*n +: 8] = 8'ha0 + 8'(n);
            ld(11'h020, exp);
        end
        drbs_master_i.access(1'b1, 2'h1, 1'b0, 11'h022, 32'h0000_beef, 0, lat, rd);
        exp[31:16] = 16'hbeef;
        drbs_master_i.access(1'b0, 2'h0, 1'b0, 11'h021, 32'h0, 0, lat, rd);
        chk(rd, exp);
    endtask : t_lanes

    // Store behind a pending transfer: ack waits, data is written at once
    task automatic t_hold;
        drbs_master_i.access(1'b1, 2'h2, 1'b0, 11'h030, 32'h600d_f00d, 3, lat, rd);
        chk(lat, 5);
        drbs_master_i.access(1'b0, 2'h2, 1'b0, 11'h030, 32'h0, 3, lat, rd);
        chk(lat, 1);
        chk(rd, 32'h600d_f00d);
    endtask : t_hold

    // Violating accesses get no ack and leave the word alone
    task automatic t_refuse;
        logic [1:0] sz [4] = '{2'h2, 2'h1, 2'h2, 2'h3};
        logic [10:0] ad [4] = '{11'h040, 11'h041, 11'h042, 11'h040};
        drbs_master_i.access(1'b1, 2'h2, 1'b0, 11'h040, 32'h0f0f_0f0f, 0, lat, rd);
        for (int n = 0; n < 4; n++)
        begin
            drbs_master_i.access(1'b1, sz[n], n == 0, ad[n], 32'hdead_0000, 0, lat, rd);
            chk(lat, 0);
        end
        set_en(1'b0);
        drbs_master_i.access(1'b1, 2'h2, 1'b0, 11'h040, 32'hdead_0001, 0, lat, rd);
        chk(lat, 0);
        set_en(1'b1);
        ld(11'h040, 32'h0f0f_0f0f);
        chk(n_refd, 32'h5);
    endtask : t_refuse

    // Decompressor read: answered only while bus mode is off
    task automatic idu_rd(input logic want_ack);
        @(posedge clock);
        idu_req <= 1'b1;
        idu_addr <= 9'h010;
        @(posedge clock);
        idu_req <= 1'b0;
        idu_addr <= 9'h1ef;
        @(negedge clock);
        chk(iack, want_ack);
        if (want_ack)
            chk(ird, 32'h0f0f_0f0f);
    endtask : idu_rd

    task automatic t_idu;
        set_en(1'b0);
        idu_rd(1'b1);
        set_en(1'b1);
        idu_rd(1'b0);
    endtask : t_idu

    initial
    begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        t_word();
        t_lanes();
        t_hold();
        t_refuse();
        t_idu();
        test_done();
    end
endmodule : tb_top
`default_nettype wire

//--- verilog/drbs_bank.sv
// One 16-bit RAM bank with two byte write enables and a registered read.
// Assumes a single clock; read and write share one address per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "drbs_cfg.svh"

module drbs_bank
#(
    parameter int DEPTH = `DRBS_DEPTH,
    parameter int IDX_W = `DRBS_IDX_W
)
(
    input wire logic clock,
    input wire logic [IDX_W-1:0] idx,
    input wire logic rd_en,
    input wire logic [1:0] wr_be,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata
);

    // One byte-wide array per lane, so each array has a single writer;
    // untouched bytes of an entry keep their value on narrow stores
    for (genvar b = 0; b < 2; b++)
    begin : g_lane
        logic [7:0] mem [DEPTH];
        logic [7:0] rdata_r;
        logic [7:0] rdata_nxt;

        // Read port: output holds until the next read
        always_comb
        begin
            rdata_nxt = rdata_r;
            if (rd_en)
            begin
                rdata_nxt = mem[idx];
            end
        end

        // Registered read byte and per-byte write
        always_ff @(posedge clock)
        begin
            rdata_r <= rdata_nxt;
            if (wr_be[b])
            begin
                mem[idx] <= wdata[b*8 +: 8];
            end
        end

        assign rdata[b*8 +: 8] = rdata_r;
    end

endmodule : drbs_bank
`default_nettype wire

//--- verilog/drbs_cfg.svh
// Constants for the decompression RAM bus slave: sizes, geometry, lanes.
// Included by bare name from every design file that needs a figure.
`ifndef DRBS_CFG_SVH
`define DRBS_CFG_SVH

// Storage geometry: 2 Kbytes as two 16-bit banks of 512 entries
`define DRBS_DEPTH 512
`define DRBS_IDX_W 9
`define DRBS_ADDR_W 11
`define DRBS_BANK_W 16
`define DRBS_WORD_W 32

// Byte address fields
`define DRBS_IDX_LSB 2
`define DRBS_IDX_MSB 10
`define DRBS_BYTE_LSB 0
`define DRBS_BYTE_MSB 1
`define DRBS_HALF_BIT 1

// Transfer size codes on the bus
`define DRBS_SZ_BYTE 2'h0
`define DRBS_SZ_HALF 2'h1
`define DRBS_SZ_WORD 2'h2

// Byte enable patterns
`define DRBS_BE_NONE 4'h0
`define DRBS_BE_BYTE0 4'h1
`define DRBS_BE_HALF0 4'h3
`define DRBS_BE_WORD 4'hf

`endif

//--- verilog/drbs_lanes.sv
// Lane decoder: byte enables and steered write data from size and address.
// Assumes byte address bits [1:0] select lane 0..3, lane 0 in bits 7:0.
`timescale 1ns/1ps
`default_nettype none
`include "drbs_cfg.svh"

module drbs_lanes
(
    input wire logic [1:0] addr_lo,
    input wire logic [1:0] size,
    input wire logic [31:0] wdata_in,
    output logic [3:0] byte_en,
    output logic [31:0] wdata_out,
    output logic aligned
);

    // Replicate narrow data over all lanes; enables pick the live ones
    always_comb
    begin
        byte_en = `DRBS_BE_NONE;
        wdata_out = wdata_in;
        aligned = 1'b0;
        unique case (size)
            `DRBS_SZ_BYTE:
            begin
                byte_en = 4'(`DRBS_BE_BYTE0 << addr_lo);
                wdata_out = {4{wdata_in[7:0]}};
                aligned = 1'b1;
            end
            `DRBS_SZ_HALF:
            begin
                byte_en = 4'(`DRBS_BE_HALF0 << {addr_lo[`DRBS_HALF_BIT], 1'b0});
                wdata_out = {2{wdata_in[15:0]}};
                aligned = ~addr_lo[0];
            end
            `DRBS_SZ_WORD:
            begin
                byte_en = `DRBS_BE_WORD;
                aligned = (addr_lo == 2'h0);
            end
            default:
            begin
                byte_en = `DRBS_BE_NONE;
                aligned = 1'b0;
            end
        endcase
        // Misaligned or illegal size touches nothing
        if (!aligned)
        begin
            byte_en = `DRBS_BE_NONE;
        end
    end

endmodule : drbs_lanes
`default_nettype wire

//--- verilog/drbs_pkg.sv
// Types shared by the decompression RAM bus slave.
// Assumes drbs_cfg.svh holds the numeric figures.
`default_nettype none

package drbs_pkg;

    // Bus side sequencer: Gray along idle -> hold -> ack; ack -> idle and idle -> ack flip both bits
    typedef enum logic [1:0] {
        DRBS_IDLE = 2'h0,
        DRBS_HOLD = 2'h1,
        DRBS_ACK = 2'h3
    } drbs_state_t;

endpackage : drbs_pkg

`default_nettype wire

//--- verilog/drbs_top.sv
// Decompression RAM slave on the internal bus, with decompressor port.
// Assumes one system clock, synchronous reset, single-beat bus masters
// and a bus that times out any access this slave leaves unanswered.
`timescale 1ns/1ps
`default_nettype none
`include "drbs_cfg.svh"

module drbs_top
#(
    parameter int DEPTH = `DRBS_DEPTH,
    parameter int IDX_W = `DRBS_IDX_W,
    parameter int ADDR_W = `DRBS_ADDR_W
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic direct_ram_access_enable,
    input wire logic bus_valid,
    input wire logic bus_write,
    input wire logic [1:0] bus_size,
    input wire logic bus_burst,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_prev_pending,
    output logic bus_ready,
    output logic bus_ack,
    output logic [31:0] bus_rdata,
    output logic bus_refused,
    input wire logic idu_req,
    input wire logic [IDX_W-1:0] idu_addr,
    output logic idu_ack,
    output logic [31:0] idu_rdata
);

    drbs_pkg::drbs_state_t state_r;
    drbs_pkg::drbs_state_t state_nxt;
    logic refused_r;
    logic refused_nxt;
    logic idu_ack_r;
    logic idu_ack_nxt;

    logic bus_take;
    logic bus_ok;
    logic bus_wr_go;
    logic bus_rd_go;
    logic idu_take;
    logic aligned;
    logic [3:0] byte_en;
    logic [3:0] wr_be;
    logic [31:0] wdata_lanes;
    logic [IDX_W-1:0] bank_idx;
    logic bank_rd;
    logic [15:0] lo_q;
    logic [15:0] hi_q;
    logic shadow_valid_r;
    logic shadow_valid_nxt;
    logic [IDX_W-1:0] shadow_idx_r;
    logic [IDX_W-1:0] shadow_idx_nxt;
    logic [31:0] shadow_word_r;
    logic [31:0] shadow_word_nxt;

    // Lane decode for the current bus request
    drbs_lanes u_lanes
    (
        .addr_lo(bus_addr[`DRBS_BYTE_MSB:`DRBS_BYTE_LSB]),
        .size(bus_size),
        .wdata_in(bus_wdata),
        .byte_en(byte_en),
        .wdata_out(wdata_lanes),
        .aligned(aligned)
    );

    assign bus_ready = (state_r == drbs_pkg::DRBS_IDLE);
    assign bus_take = bus_valid && bus_ready;

    assign bus_ok = direct_ram_access_enable && !bus_burst && aligned;
    assign bus_wr_go = bus_take && bus_ok && bus_write;
    assign bus_rd_go = bus_take && bus_ok && !bus_write;

    assign idu_take = idu_req && !direct_ram_access_enable;

    assign wr_be = bus_wr_go ? byte_en : `DRBS_BE_NONE;

    assign bank_idx = direct_ram_access_enable
        ? bus_addr[`DRBS_IDX_MSB:`DRBS_IDX_LSB] : idu_addr;
    assign bank_rd = bus_rd_go || idu_take;

    drbs_bank #(.DEPTH(DEPTH), .IDX_W(IDX_W)) u_bank_lo
    (
        .clock(clock),
        .idx(bank_idx),
        .rd_en(bank_rd),
        .wr_be(wr_be[1:0]),
        .wdata(wdata_lanes[15:0]),
        .rdata(lo_q)
    );

    drbs_bank #(.DEPTH(DEPTH), .IDX_W(IDX_W)) u_bank_hi
    (
        .clock(clock),
        .idx(bank_idx),
        .rd_en(bank_rd),
        .wr_be(wr_be[3:2]),
        .wdata(wdata_lanes[31:16]),
        .rdata(hi_q)
    );

    assign bus_rdata = {hi_q, lo_q};
    assign idu_rdata = {hi_q, lo_q};

    // Sequencer next state; a refused access leaves the slave idle
    always_comb
    begin
        state_nxt = state_r;
        refused_nxt = bus_take && !bus_ok;
        idu_ack_nxt = idu_take;
        unique case (state_r)
            drbs_pkg::DRBS_IDLE:
            begin
                if (bus_wr_go && bus_prev_pending)
                begin
                    state_nxt = drbs_pkg::DRBS_HOLD;
                end
                else if (bus_wr_go || bus_rd_go)
                begin
                    state_nxt = drbs_pkg::DRBS_ACK;
                end
            end
            drbs_pkg::DRBS_HOLD:
            begin
                if (!bus_prev_pending)
                begin
                    state_nxt = drbs_pkg::DRBS_ACK;
                end
            end
            drbs_pkg::DRBS_ACK:
            begin
                state_nxt = drbs_pkg::DRBS_IDLE;
            end
            default:
            begin
                state_nxt = drbs_pkg::DRBS_IDLE;
            end
        endcase
    end

    // Registers only; reset parks everything idle
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_r <= drbs_pkg::DRBS_IDLE;
            refused_r <= 1'b0;
            idu_ack_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            refused_r <= refused_nxt;
            idu_ack_r <= idu_ack_nxt;
        end
    end

    assign bus_ack = (state_r == drbs_pkg::DRBS_ACK);
    assign bus_refused = refused_r;
    assign idu_ack = idu_ack_r;

    // Checks on the slave's outputs and its internal write enables
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_take_read;
        bus_take && bus_ok && !bus_write;
    endsequence

    sequence s_take_write_free;
        bus_take && bus_ok && bus_write && !bus_prev_pending;
    endsequence

    sequence s_take_write_held;
        bus_take && bus_ok && bus_write && bus_prev_pending;
    endsequence

    sequence s_take_bad;
        bus_take && !bus_ok;
    endsequence

    sequence s_take_off;
        bus_take && !direct_ram_access_enable;
    endsequence

    sequence s_take_half_hi;
        bus_wr_go && bus_size == `DRBS_SZ_HALF && bus_addr[`DRBS_HALF_BIT];
    endsequence

    sequence s_read_shadow;
        bus_rd_go && shadow_valid_r && bank_idx == shadow_idx_r;
    endsequence

    sequence s_held_wait;
        state_r == drbs_pkg::DRBS_HOLD && bus_prev_pending;
    endsequence

    sequence s_held_free;
        state_r == drbs_pkg::DRBS_HOLD && !bus_prev_pending;
    endsequence

    // Shadow of the last full-word store, kept from bus inputs only;
    // any narrow store clears it, so the check never guesses merged lanes
    always_comb
    begin
        shadow_valid_nxt = shadow_valid_r;
        shadow_idx_nxt = shadow_idx_r;
        shadow_word_nxt = shadow_word_r;
        if (bus_wr_go)
        begin
            shadow_valid_nxt = (bus_size == `DRBS_SZ_WORD);
            shadow_idx_nxt = bus_addr[`DRBS_IDX_MSB:`DRBS_IDX_LSB];
            shadow_word_nxt = bus_wdata;
        end
    end

    // Shadow registers; only the valid flag needs a reset
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            shadow_valid_r <= 1'b0;
        end
        else
        begin
            shadow_valid_r <= shadow_valid_nxt;
        end
        shadow_idx_r <= shadow_idx_nxt;
        shadow_word_r <= shadow_word_nxt;
    end

    bus_enable_gate_a: assert property (s_take_off |-> wr_be == `DRBS_BE_NONE ##1 !bus_ack)
        else $error("bus access served without direct access enable");

    idu_lockout_a: assert property (idu_req && direct_ram_access_enable |=> !idu_ack)
        else $error("decompressor served in bus mode");

    idu_answer_a: assert property (idu_req && !direct_ram_access_enable |=> idu_ack)
        else $error("decompressor read not answered next cycle");

    read_ack_a: assert property (s_take_read |=> bus_ack ##1 bus_ready)
        else $error("read not acknowledged next cycle");

    // high half lands in second bank
    bank_pair_a: assert property (s_take_half_hi |-> u_bank_hi.wr_be == 2'(`DRBS_BE_HALF0)
        && u_bank_lo.wr_be == 2'(`DRBS_BE_NONE) && u_bank_hi.wdata == bus_wdata[15:0])
        else $error("upper half not steered to the second bank");

    word_read_a: assert property (s_read_shadow |=> bus_rdata == $past(shadow_word_r))
        else $error("read does not return the full written word");

    no_overlap_a: assert property (bus_wr_go || bus_rd_go |=> !bus_ready)
        else $error("second transfer taken while busy");

    ack_pulse_a: assert property (bus_ack |=> !bus_ack && bus_ready)
        else $error("acknowledge longer than one cycle");

    held_store_a: assert property (s_take_write_held |-> wr_be != `DRBS_BE_NONE ##1 !bus_ack)
        else $error("held store written late or acknowledged early");

    held_wait_a: assert property (s_held_wait |=> !bus_ack)
        else $error("held store acknowledged while predecessor pending");

    held_release_a: assert property (s_held_free |=> bus_ack)
        else $error("held store not acknowledged after predecessor");

    store_free_a: assert property (s_take_write_free |=> bus_ack)
        else $error("free store not acknowledged next cycle");

    refuse_noack_a: assert property (s_take_bad |=> !bus_ack && bus_refused ##1 !bus_ack)
        else $error("refused access acknowledged");

    burst_noack_a: assert property (bus_take && bus_burst |-> wr_be == `DRBS_BE_NONE ##1 !bus_ack)
        else $error("burst access served");

    byte_lane_a: assert property (bus_wr_go && bus_size == `DRBS_SZ_BYTE |-> $onehot(wr_be))
        else $error("byte write touches more than one lane");

endmodule : drbs_top
`default_nettype wire
